// ==== hw/rcd_top.sv ====
// Resampling comb stage followed by the fifth-order decimator, APB configured
// How it works
// - Resampler decimates by the 12-bit stored value plus one.
// - Resampler zero-stuffs by the 9-bit stored value plus one.
// - Low five scale bits attenuate the input under strong signal.
// - Next five scale bits attenuate the input under weak signal.
// - Exponent weight bit picks 6 dB or 12 dB per exponent step.
// - Invert bit replaces the exponent by seven minus exponent.
// - One-to-one ratio bypasses the resampling comb but still applies input scaling.
// - Fifth-order decimator accepts ratios 2 through 32.
// - Fifth-order scale 0 to 20, 6 dB per step.
// - Five integrator-comb sections, gain divided by two to scale plus five.
// - Fifth-order decimator keeps up with full 80 MHz input.
// - One fifth-order output per ratio input samples.
// - Level indicator picks the scale; shift is exponent plus scale mod 32.
// - Zero-stuff by interpolation, then second-order comb decimating by M.
`timescale 1ns/1ps
`default_nettype none
`include "rcd_consts.svh"
module rcd_top
    import rcd_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Samples from the frequency translator
    input wire logic in_valid,
    input wire rcd_in_t in_smp,
    input wire logic level_indicator,
    output logic in_ready,
    // Samples toward the coefficient filter
    output logic out_valid,
    output rcd_out_t out_smp
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // -----------------------------------------------------------------
    // Register file
    // -----------------------------------------------------------------
    logic [11:0] dec_reg;
    logic [8:0] int_reg;
    logic [11:0] scl_reg;
    logic [5:0] c5_ratio_reg;
    logic [4:0] c5_scale_reg;
    logic [15:0] out_cnt_reg;
    logic [4:0] shift_now;
    rcd_state_t state_reg;
    logic [9:0] idx;
    logic hit;
    logic wr_acc;
    logic [31:0] rd_mux;
    logic [5:0] wr_ratio;
    logic [4:0] wr_scale;

    assign idx = paddr[11:2];
    assign hit = (idx >= `RCD_IDX_DEC) && (idx <= `RCD_IDX_STAT);
    assign wr_acc = psel && penable && pwrite && hit;
    // Zero wait state: every access ends in its first access cycle
    assign pready = psel && penable;
    assign pslverr = psel && penable && (!hit || (pwrite && idx == `RCD_IDX_STAT));
    assign wr_ratio = pwdata[`RCD_C5_RATIO_LSB +: 6];
    assign wr_scale = pwdata[`RCD_C5_SCALE_LSB +: 5];

    // Read mux; unmapped words read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx)
            `RCD_IDX_DEC: rd_mux[11:0] = dec_reg;
            `RCD_IDX_INT: rd_mux[8:0] = int_reg;
            `RCD_IDX_SCL: rd_mux[11:0] = scl_reg;
            `RCD_IDX_C5: begin
                rd_mux[`RCD_C5_RATIO_LSB +: 6] = c5_ratio_reg;
                rd_mux[`RCD_C5_SCALE_LSB +: 5] = c5_scale_reg;
            end
            `RCD_IDX_STAT: begin
                rd_mux[0] = (state_reg == RCD_RUN);
                rd_mux[12:8] = shift_now;
                rd_mux[31:16] = out_cnt_reg;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data captured in the setup cycle so it leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Writes; out-of-range fifth-order settings are clamped at entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_reg <= `RCD_DEC_RST;
            int_reg <= `RCD_INT_RST;
            scl_reg <= `RCD_SCL_RST;
            c5_ratio_reg <= `RCD_C5_RATIO_RST;
            c5_scale_reg <= `RCD_C5_SCALE_RST;
        end else if (wr_acc) begin
            if (idx == `RCD_IDX_DEC) dec_reg <= pwdata[11:0];
            if (idx == `RCD_IDX_INT) int_reg <= pwdata[8:0];
            if (idx == `RCD_IDX_SCL) scl_reg <= pwdata[11:0];
            if (idx == `RCD_IDX_C5) begin
                if (wr_ratio < `RCD_C5_RATIO_MIN) c5_ratio_reg <= `RCD_C5_RATIO_MIN;
                else if (wr_ratio > `RCD_C5_RATIO_MAX) c5_ratio_reg <= `RCD_C5_RATIO_MAX;
                else c5_ratio_reg <= wr_ratio;
                if (wr_scale > `RCD_C5_SCALE_MAX) c5_scale_reg <= `RCD_C5_SCALE_MAX;
                else c5_scale_reg <= wr_scale;
            end
        end
    end

    // -----------------------------------------------------------------
    // Input scaling
    // -----------------------------------------------------------------
    logic [2:0] exp_eff;
    logic [4:0] scl_sel;
    logic [5:0] exp_db;
    logic [5:0] shift_sum;
    logic signed [23:0] in_wide;
    logic signed [23:0] scaled;

    // Inverted exponent counts down from the top code
    assign exp_eff = scl_reg[`RCD_SCL_INV_BIT] ? (`RCD_EXP_TOP - in_smp.exp) : in_smp.exp;
    // 12 dB steps are two 6 dB shifts
    assign exp_db = scl_reg[`RCD_SCL_WEIGHT_BIT] ? {2'b00, exp_eff, 1'b0} : {3'b000, exp_eff};
    // Level indicator chooses the attenuator-compensated field
    assign scl_sel = level_indicator ? scl_reg[`RCD_SCL_STRONG_LSB +: 5]
                                     : scl_reg[`RCD_SCL_WEAK_LSB +: 5];
    assign shift_sum = exp_db + {1'b0, scl_sel};
    assign shift_now = shift_sum[4:0];
    // Fraction bits below the input keep small-signal detail after the shift
    assign in_wide = {in_smp.data, {`RCD_FRAC_BITS{1'b0}}};
    assign scaled = in_wide >>> shift_now;

    // -----------------------------------------------------------------
    // Resampling comb stage
    // -----------------------------------------------------------------
    logic signed [23:0] hold_reg;
    logic [8:0] phase_reg;
    logic [11:0] dcnt_reg;
    logic signed [47:0] i1_reg, i2_reg, d1_reg, d2_reg;
    logic signed [47:0] x_now, i1_next, i2_next, c1_next, c2_next;
    logic r_valid;
    logic signed [23:0] r_data;
    logic emit;
    logic bypass;

    // One sample per L+1 cycles; at 200 MHz this clears 80 MHz only when L is 1
    assign in_ready = (state_reg == RCD_IDLE);
    // Zero-stuffed stream: sample on the first phase, zeros after
    assign x_now = (phase_reg == 9'h000) ? 48'(hold_reg) : 48'sh0;
    assign i1_next = i1_reg + x_now;
    assign i2_next = i2_reg + i1_next;
    assign c1_next = i2_next - d1_reg;
    assign c2_next = c1_next - d2_reg;
    assign emit = (state_reg == RCD_RUN) && (dcnt_reg == dec_reg);
    // Ratio 1/1 skips the filter but keeps the input scaling
    assign bypass = (dec_reg == 12'h000) && (int_reg == 9'h000);

    // Sequencer: one stuffed phase per cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= RCD_IDLE;
            phase_reg <= 9'h000;
            hold_reg <= 24'sh0;
        end else begin
            case (state_reg)
                RCD_IDLE: begin
                    if (in_valid) begin
                        hold_reg <= scaled;
                        phase_reg <= 9'h000;
                        state_reg <= RCD_RUN;
                    end
                end
                RCD_RUN: begin
                    if (phase_reg == int_reg) state_reg <= RCD_IDLE;
                    else phase_reg <= phase_reg + 9'h001;
                end
                default: state_reg <= RCD_IDLE;
            endcase
        end
    end

    // Two integrators, two combs at the decimated instants
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            i1_reg <= 48'sh0;
            i2_reg <= 48'sh0;
            d1_reg <= 48'sh0;
            d2_reg <= 48'sh0;
            dcnt_reg <= 12'h000;
        end else if (state_reg == RCD_RUN) begin
            i1_reg <= i1_next;
            i2_reg <= i2_next;
            if (emit) begin
                dcnt_reg <= 12'h000;
                d1_reg <= i2_next;
                d2_reg <= c1_next;
            end else begin
                dcnt_reg <= dcnt_reg + 12'h001;
            end
        end
    end

    // At 1/1 the held sample goes out directly, so no stale comb history leaks in
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_valid <= 1'b0;
            r_data <= 24'sh0;
        end else begin
            r_valid <= emit;
            if (emit && bypass) r_data <= hold_reg;
            else if (emit) r_data <= c2_next[23:0];
        end
    end

    // -----------------------------------------------------------------
    // Fifth-order decimator
    // -----------------------------------------------------------------
    logic signed [49:0] ig_reg [5];
    logic signed [49:0] ig_next [5];
    logic signed [49:0] dl_reg [5];
    logic signed [49:0] cb_val [6];
    logic [5:0] c5cnt_reg;
    logic c5_emit;
    logic [5:0] c5_shift;
    logic signed [49:0] c5_scaled;

    assign c5_emit = r_valid && (c5cnt_reg == c5_ratio_reg - 6'h01);
    assign cb_val[0] = ig_next[4];

    // Integrator cascade and comb cascade, one section per step
    for (genvar k = 0; k < 5; k++) begin : g_sec
        if (k == 0) begin : g_first
            assign ig_next[k] = ig_reg[k] + 50'(r_data);
        end else begin : g_rest
            assign ig_next[k] = ig_reg[k] + ig_next[k-1];
        end
        assign cb_val[k+1] = cb_val[k] - dl_reg[k];
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ig_reg[k] <= 50'sh0;
                dl_reg[k] <= 50'sh0;
            end else if (r_valid) begin
                ig_reg[k] <= ig_next[k];
                if (c5_emit) dl_reg[k] <= cb_val[k];
            end
        end
    end

    // Gain removed as two to the scale plus five
    assign c5_shift = {1'b0, c5_scale_reg} + `RCD_C5_BASE_SHIFT;
    assign c5_scaled = cb_val[5] >>> c5_shift;

    // Ratio counter and registered output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c5cnt_reg <= 6'h00;
            out_valid <= 1'b0;
            out_smp <= '0;
            out_cnt_reg <= 16'h0000;
        end else begin
            out_valid <= c5_emit;
            if (r_valid) c5cnt_reg <= c5_emit ? 6'h00 : c5cnt_reg + 6'h01;
            if (c5_emit) begin
                out_smp.data <= c5_scaled[23:0];
                out_cnt_reg <= out_cnt_reg + 16'h0001;
            end
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    sequence s_take;
        in_valid && in_ready ##1 state_reg == RCD_RUN;
    endsequence
    property p_take;
        in_valid && in_ready |-> s_take;
    endproperty
    a_take: assert property (p_take) else $error("input not taken");
    property p_run_len;
        state_reg == RCD_RUN && phase_reg == int_reg |=> in_ready;
    endproperty
    a_run_len: assert property (p_run_len) else $error("stuffing length wrong");
    property p_busy;
        state_reg == RCD_RUN && phase_reg != int_reg |=> !in_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("stuffing ended early");
    property p_dec;
        state_reg == RCD_RUN |=> r_valid == ($past(dcnt_reg) == $past(dec_reg));
    endproperty
    a_dec: assert property (p_dec) else $error("resampler decimation wrong");
    property p_bypass;
        in_valid && in_ready && dec_reg == 12'h000 && int_reg == 9'h000
            |-> ##2 r_valid && r_data == $past(scaled, 2);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass altered sample");
    property p_shift;
        !scl_reg[`RCD_SCL_INV_BIT] && !scl_reg[`RCD_SCL_WEIGHT_BIT] && level_indicator
            |-> shift_now == 5'(in_smp.exp + scl_reg[4:0]);
    endproperty
    a_shift: assert property (p_shift) else $error("scale shift wrong");
    property p_c5_out;
        out_valid |-> $past(r_valid) && $past(c5cnt_reg) == $past(c5_ratio_reg) - 6'h01;
    endproperty
    a_c5_out: assert property (p_c5_out) else $error("decimator output off ratio");
    property p_c5_range;
        c5_ratio_reg >= `RCD_C5_RATIO_MIN && c5_ratio_reg <= `RCD_C5_RATIO_MAX
            && c5_scale_reg <= `RCD_C5_SCALE_MAX;
    endproperty
    a_c5_range: assert property (p_c5_range) else $error("decimator setting out of range");
    property p_c5_data;
        c5_emit |=> out_smp.data == $past(c5_scaled[23:0]);
    endproperty
    a_c5_data: assert property (p_c5_data) else $error("decimator output not scaled");
    property p_weight;
        scl_reg[`RCD_SCL_WEIGHT_BIT] && !scl_reg[`RCD_SCL_INV_BIT] && level_indicator
            |-> shift_now == 5'({in_smp.exp, 1'b0} + scl_reg[4:0]);
    endproperty
    a_weight: assert property (p_weight) else $error("exponent weight wrong");
    property p_invert;
        scl_reg[`RCD_SCL_INV_BIT] && !scl_reg[`RCD_SCL_WEIGHT_BIT] && level_indicator
            |-> shift_now == 5'((`RCD_EXP_TOP - in_smp.exp) + scl_reg[4:0]);
    endproperty
    a_invert: assert property (p_invert) else $error("exponent invert wrong");
    property p_out_pulse;
        out_valid |=> !out_valid;
    endproperty
    a_out_pulse: assert property (p_out_pulse) else $error("decimator pulse too long");
endmodule : rcd_top
`default_nettype wire

// ==== hw/rcd_consts.svh ====
// Register map, field positions and reset values of the decimation chain
`ifndef RCD_CONSTS_SVH
`define RCD_CONSTS_SVH
// -----------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define RCD_IDX_DEC 10'h090
`define RCD_IDX_INT 10'h091
`define RCD_IDX_SCL 10'h092
`define RCD_IDX_C5 10'h093
`define RCD_IDX_STAT 10'h094
// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define RCD_SCL_STRONG_LSB 0
`define RCD_SCL_WEAK_LSB 5
`define RCD_SCL_WEIGHT_BIT 10
`define RCD_SCL_INV_BIT 11
`define RCD_C5_RATIO_LSB 0
`define RCD_C5_SCALE_LSB 8
// -----------------------------------------------------------------
// Reset values and limits
// -----------------------------------------------------------------
`define RCD_DEC_RST 12'h000
`define RCD_INT_RST 9'h000
`define RCD_SCL_RST 12'h000
`define RCD_C5_RATIO_RST 6'h02
`define RCD_C5_RATIO_MIN 6'h02
`define RCD_C5_RATIO_MAX 6'h20
`define RCD_C5_SCALE_RST 5'h00
`define RCD_C5_SCALE_MAX 5'h14
`define RCD_C5_BASE_SHIFT 6'h05
`define RCD_FRAC_BITS 10
`define RCD_EXP_TOP 3'h7
`endif

// ==== hw/rcd_pkg.sv ====
// Types shared by the decimation chain
`default_nettype none
package rcd_pkg;
    // Wideband input sample with its converter exponent
    typedef struct packed {
        logic signed [13:0] data;
        logic [2:0] exp;
    } rcd_in_t;
    // Sample leaving toward the coefficient filter
    typedef struct packed {
        logic signed [23:0] data;
    } rcd_out_t;
    // Resampler sequencing, one-hot
    typedef enum logic [1:0] {
        RCD_IDLE = 2'b01,
        RCD_RUN = 2'b10
    } rcd_state_t;
endpackage : rcd_pkg
`default_nettype wire

// ==== tb/rcd_src_model.sv ====
// Sample source standing in for the upstream frequency translator
`timescale 1ns/1ps
`default_nettype none
module rcd_src_model
    import rcd_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench control
    input var int quota,
    input wire rcd_in_t smp_val,
    // Toward the chain
    input wire logic in_ready,
    output logic in_valid,
    output rcd_in_t in_smp,
    output int taken
);
    int taken_n;

    // Count after this edge, so the offer stops exactly at the quota
    always_comb begin
        taken_n = taken + int'(in_valid && in_ready);
    end

    // Hold each sample until taken; idle data toggles so no stale word is trusted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_valid <= 1'b0;
            in_smp <= '0;
            taken <= 0;
        end else begin
            taken <= taken_n;
            in_valid <= (taken_n < quota);
            if (taken_n < quota) begin
                in_smp <= smp_val;
            end else begin
                in_smp <= ~in_smp;
            end
        end
    end
endmodule : rcd_src_model
`default_nettype wire

// ==== tb/resampling_cic_and_fifth_order_decimator_decimator_tb.sv ====
// Self-checking bench for the resampler and fifth-order decimator chain
`timescale 1ns/1ps
`default_nettype none
`include "rcd_consts.svh"
module resampling_cic_and_fifth_order_decimator_decimator_tb
    import rcd_pkg::*;
;
    // ----------------------------------------------------------
    // Signals, clock and instances
    // ----------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic level_indicator = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, in_valid, in_ready, out_valid;
    rcd_in_t in_smp;
    rcd_in_t smp_val = '0;
    rcd_out_t out_smp;
    int quota = 0;
    int taken;
    int error_cnt = 0;
    int total_checks = 0;

    // 200 MHz
    always #2.5 pclk = ~pclk;

    rcd_top i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_valid(in_valid), .in_smp(in_smp), .level_indicator(level_indicator),
        .in_ready(in_ready), .out_valid(out_valid), .out_smp(out_smp)
    );
    rcd_src_model i_src (
        .pclk(pclk), .presetn(presetn), .quota(quota), .smp_val(smp_val),
        .in_ready(in_ready), .in_valid(in_valid), .in_smp(in_smp), .taken(taken)
    );

    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    // One APB transfer; the request stands until pready is seen high
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk(32'h0, 32'h1);
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp, input logic eerr);
        logic [31:0] rd;
        logic e;
        apb(1'b0, idx, 32'h0, rd, e);
        chk(rd, exp);
        chk({31'h0, e}, {31'h0, eerr});
    endtask : rdchk

    task automatic wrchk(input logic [9:0] idx, input logic [31:0] wd, input logic eerr);
        logic [31:0] rd;
        logic e;
        apb(1'b1, idx, wd, rd, e);
        chk({31'h0, e}, {31'h0, eerr});
    endtask : wrchk

    // Full setup; stream settings go in by the edge after the last write
    task automatic cfg(input logic [31:0] scl, input logic [31:0] dec, input logic [31:0] ip,
                       input logic [31:0] c5, input logic lvl, input rcd_in_t smp);
        wrchk(`RCD_IDX_SCL, scl, 1'b0);
        wrchk(`RCD_IDX_DEC, dec, 1'b0);
        wrchk(`RCD_IDX_INT, ip, 1'b0);
        wrchk(`RCD_IDX_C5, c5, 1'b0);
        level_indicator <= lvl;
        smp_val <= smp;
    endtask : cfg

    // Offer n samples, then watch 12 more edges for the tail of the pipeline
    task automatic run(input int n, output int outs, output logic [23:0] last, output int low);
        int tgt;
        int w;
        int lo;
        tgt = quota + n;
        outs = 0;
        low = 0;
        lo = 0;
        w = 0;
        last = '0;
        @(posedge pclk);
        quota <= tgt;
        for (int c = 0; c < 5000 && w < 12; c++) begin
            @(posedge pclk);
            if (out_valid === 1'b1) begin
                outs++;
                last = out_smp.data;
            end
            if (in_ready === 1'b0) begin
                lo++;
            end else begin
                if (lo > 0) low = lo;
                lo = 0;
            end
            if (taken == tgt) w++;
        end
        if (w < 12) begin
            chk(32'h0, 32'h1);
            tally_and_finish();
        end
    endtask : run

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_regs();
        rdchk(`RCD_IDX_DEC, 32'h0, 1'b0);
        rdchk(`RCD_IDX_INT, 32'h0, 1'b0);
        rdchk(`RCD_IDX_SCL, 32'h0, 1'b0);
        rdchk(`RCD_IDX_C5, 32'h2, 1'b0);
        wrchk(`RCD_IDX_DEC, 32'hffffffff, 1'b0);
        rdchk(`RCD_IDX_DEC, 32'hfff, 1'b0);
        wrchk(`RCD_IDX_INT, 32'hffffffff, 1'b0);
        rdchk(`RCD_IDX_INT, 32'h1ff, 1'b0);
        wrchk(`RCD_IDX_SCL, 32'hffffffff, 1'b0);
        rdchk(`RCD_IDX_SCL, 32'hfff, 1'b0);
        wrchk(`RCD_IDX_C5, 32'h1f3f, 1'b0);
        rdchk(`RCD_IDX_C5, 32'h1420, 1'b0);
        wrchk(`RCD_IDX_C5, 32'h0001, 1'b0);
        rdchk(`RCD_IDX_C5, 32'h0002, 1'b0);
        wrchk(10'h0c0, 32'h1, 1'b1);
        rdchk(10'h0c0, 32'h0, 1'b1);
        wrchk(`RCD_IDX_STAT, 32'h1, 1'b1);
        $display("test registers done");
    endtask : t_regs

    // Bypass 1/1 with every scale path; negative input checks the arithmetic shift
    task automatic t_scale();
        logic [11:0] scl[6] = '{12'h003, 12'h043, 12'h401, 12'h800, 12'h01f, 12'hc00};
        logic lvl[6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        logic [2:0] ex[6] = '{3'h1, 3'h1, 3'h2, 3'h5, 3'h2, 3'h6};
        int sh[6] = '{4, 3, 5, 2, 1, 2};
        int outs;
        int low;
        logic [23:0] last;
        for (int i = 0; i < 6; i++) begin
            // Invert cases model an exponent that rises with level
            cfg({20'h0, scl[i]}, 32'h0, 32'h0, 32'h2, lvl[i], '{data: 14'h3000, exp: ex[i]});
            run(40, outs, last, low);
            chk(32'(outs), 32'd20);
            chk({8'h0, last}, {8'h0, 24'($signed(24'hc00000) >>> sh[i])});
        end
        $display("test input scaling done");
    endtask : t_scale

    // Power-of-two ratios with the smallest scale giving unity gain
    task automatic t_c5();
        int r[3] = '{2, 4, 32};
        int s[3] = '{0, 5, 20};
        int outs;
        int low;
        logic [23:0] last;
        for (int i = 0; i < 3; i++) begin
            cfg(32'h0, 32'h0, 32'h0, 32'((s[i] << 8) | r[i]), 1'b1, '{data: 14'h1000, exp: 3'h0});
            run(r[i] * 14, outs, last, low);
            chk(32'(outs >= 13 && outs <= 15), 32'h1);
            chk({8'h0, last}, 32'h400000);
            chk(32'(low), 32'h1);
        end
        $display("test fifth-order decimator done");
    endtask : t_c5

    task automatic t_resamp();
        int outs;
        int low;
        logic [23:0] last;
        logic [31:0] rd;
        logic e;
        // Simplest ratio 1/4; strong scale 4 cancels the gain of sixteen
        cfg(32'h4, 32'h3, 32'h0, 32'h2, 1'b1, '{data: 14'h1000, exp: 3'h0});
        run(80, outs, last, low);
        chk(32'(outs >= 9 && outs <= 11), 32'h1);
        chk({8'h0, last}, 32'h400000);
        chk(32'(low), 32'h1);
        // Ratio 3/6: three zero-stuffed phases per taken sample
        cfg(32'h0, 32'h5, 32'h2, 32'h2, 1'b1, '{data: 14'h1000, exp: 3'h0});
        run(48, outs, last, low);
        chk(32'(outs >= 11 && outs <= 13), 32'h1);
        chk(32'(low), 32'h3);
        // Ratio 2/4: stuffed gain of eight undone by strong scale 3
        cfg(32'h3, 32'h3, 32'h1, 32'h2, 1'b1, '{data: 14'h1000, exp: 3'h0});
        run(48, outs, last, low);
        chk(32'(outs), 32'd12);
        chk({8'h0, last}, 32'h400000);
        chk(32'(low), 32'h2);
        // Status: idle, 196 fifth-order outputs since reset
        apb(1'b0, `RCD_IDX_STAT, 32'h0, rd, e);
        chk(rd & 32'hffff_00ff, 32'h00c4_0000);
        chk({31'h0, e}, 32'h0);
        $display("test resampler done");
    endtask : t_resamp

    // Reset for four cycles, then the scenarios in turn
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_scale();
        t_c5();
        t_resamp();
        tally_and_finish();
    end
endmodule : resampling_cic_and_fifth_order_decimator_decimator_tb
`default_nettype wire
